// *** common/vxc_params.svh ***
// Register map, field positions, reset values and timing counts of the transfer controller
`ifndef VXC_PARAMS_SVH
`define VXC_PARAMS_SVH

`define VXC_CTRL_OFS       4'h0
`define VXC_ADDR_OFS       4'h4
`define VXC_MASK_OFS       4'h8
`define VXC_STAT_OFS       4'hC

`define VXC_CTRL_GO        0
`define VXC_CTRL_KIND_LSB  1
`define VXC_CTRL_NEWMASK   3
`define VXC_CTRL_SCRUN     4
`define VXC_CTRL_NOCAS     5
`define VXC_ADDR_ROW_LSB   0
`define VXC_ADDR_TAP_LSB   16
`define VXC_STAT_BUSY      0
`define VXC_STAT_HALF      1
`define VXC_STAT_SMODE     2
`define VXC_STAT_SCRUN     3

`define VXC_CTRL_RST       6'h00
`define VXC_ADDR_RST       32'h0000_0000
`define VXC_MASK_RST       16'hFFFF

`define VXC_CLK_NS         20
`define VXC_T_SETUP_NS     20
`define VXC_T_RCD_NS       40
`define VXC_T_CAS_NS       40
`define VXC_T_OE_NS        20
`define VXC_T_RP_NS        60
`define VXC_CYC(t)         ((((t) + `VXC_CLK_NS - 1) / `VXC_CLK_NS) < 1 ? 1 : \
                            (((t) + `VXC_CLK_NS - 1) / `VXC_CLK_NS))
`define VXC_SETUP_CYC      `VXC_CYC(`VXC_T_SETUP_NS)
`define VXC_RCD_CYC        `VXC_CYC(`VXC_T_RCD_NS)
`define VXC_CAS_CYC        `VXC_CYC(`VXC_T_CAS_NS)
`define VXC_OE_CYC         `VXC_CYC(`VXC_T_OE_NS)
`define VXC_RP_CYC         `VXC_CYC(`VXC_T_RP_NS)
`define VXC_SC_HALF_CYC    4

`endif

// *** common/vxc_pkg.sv ***
// Types shared by the transfer controller modules
package vxc_pkg;
   typedef enum logic [1:0] {
      VXC_SINGLE_READ  = 2'h0,
      VXC_SPLIT_READ   = 2'h1,
      VXC_SINGLE_WRITE = 2'h2,
      VXC_SPLIT_WRITE  = 2'h3
   } vxc_kind_t;

   typedef enum logic [2:0] {
      VXC_IDLE  = 3'h0,
      VXC_SETUP = 3'h1,
      VXC_RAS   = 3'h2,
      VXC_CAS   = 3'h3,
      VXC_OE    = 3'h4,
      VXC_PRE   = 3'h5
   } vxc_state_t;
endpackage : vxc_pkg

// *** common/vxc_seq_if.sv ***
// Order and pin bundle between the register front end and the strobe sequencer
`timescale 1ns/1ps
interface vxc_seq_if;
   logic              go;
   vxc_pkg::vxc_kind_t kind;
   logic              new_mask;
   logic              no_cas;
   logic              sc_active;
   logic [8:0]        row;
   logic [8:0]        tap;
   logic [15:0]       mask;
   logic              busy;
   logic              done;
   logic              ras_n;
   logic              cas_n;
   logic              transfer_output_enable_n;
   logic              upper_byte_write_strobe_n;
   logic              lower_byte_write_strobe_n;
   logic              function_select;
   logic [8:0]        addr;
   logic [15:0]       mask_o;
   logic              mask_oe_n;

   modport ctl (output go, kind, new_mask, no_cas, sc_active, row, tap, mask,
                input busy, done, ras_n, cas_n, transfer_output_enable_n,
                upper_byte_write_strobe_n, lower_byte_write_strobe_n,
                function_select, addr, mask_o, mask_oe_n);
   modport seq (input go, kind, new_mask, no_cas, sc_active, row, tap, mask,
                output busy, done, ras_n, cas_n, transfer_output_enable_n,
                upper_byte_write_strobe_n, lower_byte_write_strobe_n,
                function_select, addr, mask_o, mask_oe_n);
endinterface : vxc_seq_if

// *** rtl/vxc_seq.sv ***
// Strobe sequencer that runs one data transfer cycle on the memory pins
`timescale 1ns/1ps
`include "vxc_params.svh"
module vxc_seq (
   input  wire logic clk,
   input  wire logic arst_n,
   vxc_seq_if.seq    sq
);
   vxc_pkg::vxc_state_t state_q, state_d;
   vxc_pkg::vxc_kind_t  kind_q, kind_d;
   logic [3:0]          cnt_q, cnt_d;
   logic                edge_q, edge_d;
   logic                ras_n_q, ras_n_d, cas_n_q, cas_n_d, oe_n_q, oe_n_d;
   logic                wen_n_q, wen_n_d, fs_q, fs_d, done_q, done_d;
   logic                mask_oe_n_q, mask_oe_n_d;
   logic [8:0]          addr_q, addr_d, tap_q, tap_d;
   logic [15:0]         mask_q, mask_d;
   logic                cas_used_q, cas_used_d;

   always_comb begin
      state_d     = state_q;
      kind_d      = kind_q;
      cnt_d       = cnt_q;
      edge_d      = edge_q;
      ras_n_d     = ras_n_q;
      cas_n_d     = cas_n_q;
      oe_n_d      = oe_n_q;
      wen_n_d     = wen_n_q;
      fs_d        = fs_q;
      done_d      = 1'b0;
      mask_oe_n_d = mask_oe_n_q;
      addr_d      = addr_q;
      tap_d       = tap_q;
      mask_d      = mask_q;
      cas_used_d  = cas_used_q;
      if (cnt_q != 4'h0) begin
         cnt_d = cnt_q - 4'h1;
      end
      unique case (state_q)
         vxc_pkg::VXC_IDLE: begin
            if (sq.go) begin
               kind_d      = sq.kind;
               addr_d      = sq.row;
               oe_n_d      = 1'b0;
               wen_n_d     = ~sq.kind[1];
               fs_d        = sq.kind[0];
               mask_d      = sq.mask;
               mask_oe_n_d = ~(sq.kind[1] & sq.new_mask);
               tap_d       = sq.kind[0] ? {1'b0, sq.tap[7:0]} : sq.tap;
               // Writes always latch a start column so the serial side stays defined
               cas_used_d  = sq.kind[1] | ~sq.no_cas;
               edge_d      = (sq.kind == vxc_pkg::VXC_SINGLE_READ) & sq.sc_active;
               cnt_d       = 4'(`VXC_SETUP_CYC - 1);
               state_d     = vxc_pkg::VXC_SETUP;
            end
         end
         vxc_pkg::VXC_SETUP: begin
            if (cnt_q == 4'h0) begin
               ras_n_d = 1'b0;
               cnt_d   = 4'(`VXC_RCD_CYC - 1);
               state_d = vxc_pkg::VXC_RAS;
            end
         end
         vxc_pkg::VXC_RAS: begin
            // Row is held one cycle past the row strobe fall, then the start column
            // settles a full cycle before the column strobe falls, never on the same edge
            addr_d = tap_q;
            if (cnt_q == 4'h0 && addr_q == tap_q) begin
               cas_n_d     = ~cas_used_q;
               mask_oe_n_d = 1'b1;
               cnt_d       = 4'(`VXC_CAS_CYC - 1);
               state_d     = vxc_pkg::VXC_CAS;
            end
         end
         vxc_pkg::VXC_CAS: begin
            if (cnt_q == 4'h0) begin
               // For a single read with the serial clock running the transfer lands on this rising edge
               if (edge_q) begin
                  oe_n_d = 1'b1;
               end
               cnt_d   = 4'(`VXC_OE_CYC - 1);
               state_d = vxc_pkg::VXC_OE;
            end
         end
         vxc_pkg::VXC_OE: begin
            if (cnt_q == 4'h0) begin
               ras_n_d = 1'b1;
               cas_n_d = 1'b1;
               cnt_d   = 4'(`VXC_RP_CYC - 1);
               state_d = vxc_pkg::VXC_PRE;
            end
         end
         vxc_pkg::VXC_PRE: begin
            if (cnt_q == 4'h0) begin
               oe_n_d  = 1'b1;
               wen_n_d = 1'b1;
               fs_d    = 1'b0;
               done_d  = 1'b1;
               state_d = vxc_pkg::VXC_IDLE;
            end
         end
         default: begin
            state_d = vxc_pkg::VXC_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q     <= vxc_pkg::VXC_IDLE;
         kind_q      <= vxc_pkg::VXC_SINGLE_READ;
         cnt_q       <= 4'h0;
         edge_q      <= 1'b0;
         ras_n_q     <= 1'b1;
         cas_n_q     <= 1'b1;
         oe_n_q      <= 1'b1;
         wen_n_q     <= 1'b1;
         fs_q        <= 1'b0;
         done_q      <= 1'b0;
         mask_oe_n_q <= 1'b1;
         addr_q      <= 9'h000;
         tap_q       <= 9'h000;
         mask_q      <= 16'h0000;
         cas_used_q  <= 1'b0;
      end else begin
         state_q     <= state_d;
         kind_q      <= kind_d;
         cnt_q       <= cnt_d;
         edge_q      <= edge_d;
         ras_n_q     <= ras_n_d;
         cas_n_q     <= cas_n_d;
         oe_n_q      <= oe_n_d;
         wen_n_q     <= wen_n_d;
         fs_q        <= fs_d;
         done_q      <= done_d;
         mask_oe_n_q <= mask_oe_n_d;
         addr_q      <= addr_d;
         tap_q       <= tap_d;
         mask_q      <= mask_d;
         cas_used_q  <= cas_used_d;
      end
   end

   assign sq.busy                      = (state_q != vxc_pkg::VXC_IDLE);
   assign sq.done                      = done_q;
   assign sq.ras_n                     = ras_n_q;
   assign sq.cas_n                     = cas_n_q;
   assign sq.transfer_output_enable_n  = oe_n_q;
   assign sq.upper_byte_write_strobe_n = wen_n_q;
   assign sq.lower_byte_write_strobe_n = wen_n_q;
   assign sq.function_select           = fs_q;
   assign sq.addr                      = addr_q;
   assign sq.mask_o                    = mask_q;
   assign sq.mask_oe_n                 = mask_oe_n_q;
endmodule : vxc_seq

// *** rtl/vxc_top.sv ***
// Host-side transfer controller: Avalon register front end, serial clock and pin drive
//
// The placing of the registers and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
`include "vxc_params.svh"
module vxc_top #(
   parameter int unsigned SC_HALF = `VXC_SC_HALF_CYC
) (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   output logic             ras_n,
   output logic             cas_n,
   output logic             transfer_output_enable_n,
   output logic             upper_byte_write_strobe_n,
   output logic             lower_byte_write_strobe_n,
   output logic             function_select,
   output logic [8:0]       addr,
   input  wire logic [15:0] mask_data_pins_i,
   output logic      [15:0] mask_data_pins_o,
   output logic             mask_data_pins_oe_n,
   output logic             serial_clock,
   input  wire logic        half_indicator
);
   vxc_seq_if sq ();

   logic        wait_q, wait_d;
   logic [31:0] rdata_q, rdata_d;
   logic [5:0]  ctrl_q, ctrl_d;
   logic [31:0] addr_reg_q, addr_reg_d;
   logic [15:0] mask_q, mask_d;
   logic        go_q, go_d;
   logic        smode_q, smode_d;
   logic        half_s1_q, half_s2_q;
   logic [7:0]  sc_cnt_q, sc_cnt_d;
   logic        sc_q, sc_d;
   logic        take;

   // Only a write seen while waitrequest is low is taken, so each write acts once
   assign take = ~wait_q;

   always_comb begin
      wait_d     = 1'b1;
      rdata_d    = rdata_q;
      ctrl_d     = ctrl_q;
      addr_reg_d = addr_reg_q;
      mask_d     = mask_q;
      go_d       = 1'b0;
      if ((avs_read || avs_write) && wait_q) begin
         wait_d  = 1'b0;
         rdata_d = 32'h0000_0000;
         if (avs_read) begin
            unique case (avs_address)
               `VXC_CTRL_OFS: rdata_d = {26'h000_0000, ctrl_q};
               `VXC_ADDR_OFS: rdata_d = addr_reg_q;
               `VXC_MASK_OFS: rdata_d = {16'h0000, mask_q};
               `VXC_STAT_OFS: begin
                  rdata_d[`VXC_STAT_BUSY]  = sq.busy | go_q;
                  rdata_d[`VXC_STAT_HALF]  = half_s2_q;
                  rdata_d[`VXC_STAT_SMODE] = smode_q;
                  rdata_d[`VXC_STAT_SCRUN] = ctrl_q[`VXC_CTRL_SCRUN];
               end
               default: rdata_d = 32'h0000_0000;
            endcase
         end
      end
      if (avs_write && take) begin
         unique case (avs_address)
            `VXC_CTRL_OFS: begin
               ctrl_d = {avs_writedata[5:1], 1'b0};
               // A start while a transfer is in flight is dropped
               go_d   = avs_writedata[`VXC_CTRL_GO] & ~sq.busy & ~go_q;
               if (sq.busy || go_q) begin
                  ctrl_d = ctrl_q;
               end
            end
            `VXC_ADDR_OFS: addr_reg_d = {7'h00, avs_writedata[24:16], 7'h00,
                                         avs_writedata[8:0]};
            `VXC_MASK_OFS: mask_d = avs_writedata[15:0];
            default: ;
         endcase
      end
   end

   // Mirror of the far serial direction: single transfers set it, split ones leave it
   always_comb begin
      smode_d = smode_q;
      if (sq.done && !sq.kind[0]) begin
         smode_d = ~sq.kind[1];
      end
   end

   // Serial clock made here by dividing the system clock
   always_comb begin
      sc_cnt_d = sc_cnt_q;
      sc_d     = sc_q;
      if (ctrl_q[`VXC_CTRL_SCRUN]) begin
         if (sc_cnt_q == 8'(SC_HALF - 1)) begin
            sc_cnt_d = 8'h00;
            sc_d     = ~sc_q;
         end else begin
            sc_cnt_d = sc_cnt_q + 8'h01;
         end
      end else begin
         sc_cnt_d = 8'h00;
         sc_d     = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wait_q     <= 1'b1;
         rdata_q    <= 32'h0000_0000;
         ctrl_q     <= `VXC_CTRL_RST;
         addr_reg_q <= `VXC_ADDR_RST;
         mask_q     <= `VXC_MASK_RST;
         go_q       <= 1'b0;
         smode_q    <= 1'b0;
         half_s1_q  <= 1'b0;
         half_s2_q  <= 1'b0;
         sc_cnt_q   <= 8'h00;
         sc_q       <= 1'b0;
      end else begin
         wait_q     <= wait_d;
         rdata_q    <= rdata_d;
         ctrl_q     <= ctrl_d;
         addr_reg_q <= addr_reg_d;
         mask_q     <= mask_d;
         go_q       <= go_d;
         smode_q    <= smode_d;
         half_s1_q  <= half_indicator;
         half_s2_q  <= half_s1_q;
         sc_cnt_q   <= sc_cnt_d;
         sc_q       <= sc_d;
      end
   end

   assign sq.go        = go_q;
   assign sq.kind      = vxc_pkg::vxc_kind_t'(ctrl_q[`VXC_CTRL_KIND_LSB +: 2]);
   assign sq.new_mask  = ctrl_q[`VXC_CTRL_NEWMASK];
   assign sq.no_cas    = ctrl_q[`VXC_CTRL_NOCAS];
   assign sq.sc_active = ctrl_q[`VXC_CTRL_SCRUN];
   assign sq.row       = addr_reg_q[`VXC_ADDR_ROW_LSB +: 9];
   assign sq.tap       = addr_reg_q[`VXC_ADDR_TAP_LSB +: 9];
   assign sq.mask      = mask_q;

   vxc_seq u_seq (
      .clk    (clk),
      .arst_n (arst_n),
      .sq     (sq.seq)
   );

   assign avs_readdata              = rdata_q;
   assign avs_waitrequest           = wait_q;
   assign ras_n                     = sq.ras_n;
   assign cas_n                     = sq.cas_n;
   assign transfer_output_enable_n  = sq.transfer_output_enable_n;
   assign upper_byte_write_strobe_n = sq.upper_byte_write_strobe_n;
   assign lower_byte_write_strobe_n = sq.lower_byte_write_strobe_n;
   assign function_select           = sq.function_select;
   assign addr                      = sq.addr;
   assign mask_data_pins_o          = sq.mask_o;
   assign mask_data_pins_oe_n       = sq.mask_oe_n;
   assign serial_clock              = sc_q;
endmodule : vxc_top

// *** testbench/test_vxc_top.sv ***
// Self-checking bench for the transfer controller against the memory model
`timescale 1ns/1ps
module test_vxc_top;
   logic        clk = 1'b0;
   logic        arst_n = 1'b0;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata;
   logic [31:0] rv;
   logic        wreq, ras_n, cas_n, oe_n, uw_n, lw_n, fsel, sclk, half, m_oe_n;
   logic [8:0]  addr;
   logic [15:0] m_o, m_w;
   int          n_errors = 0;
   int          num_checks = 0;

   // Released mask pins show the inverse of the mask latched at the last start, never the value itself
   assign m_w = m_oe_n ? ~m_o : m_o;
   always #10 clk = ~clk;

   vxc_top #(.SC_HALF(1)) dut_u (
      .clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(wreq), .ras_n(ras_n), .cas_n(cas_n), .transfer_output_enable_n(oe_n),
      .upper_byte_write_strobe_n(uw_n), .lower_byte_write_strobe_n(lw_n),
      .function_select(fsel), .addr(addr), .mask_data_pins_i(m_w), .mask_data_pins_o(m_o),
      .mask_data_pins_oe_n(m_oe_n), .serial_clock(sclk), .half_indicator(half));
   vxc_mem_model mem_u (
      .ras_n(ras_n), .cas_n(cas_n), .transfer_output_enable_n(oe_n),
      .upper_byte_write_strobe_n(uw_n), .lower_byte_write_strobe_n(lw_n),
      .function_select(fsel), .addr(addr), .mask_data_pins(m_w), .serial_clock(sclk),
      .half_indicator(half));

   task automatic wrap_up;
      $display("errors %0d checks %0d", n_errors, num_checks);
      if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
      end
   endtask : chk

   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge clk); while (wreq !== 1'b0);
      rv = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus

   task automatic idle;
      do bus(1'b0, 4'hC, 32'h0); while (rv[0] !== 1'b0);
   endtask : idle

   task automatic go(input logic [5:0] c, input logic [8:0] row, tap, input logic [15:0] m);
      bus(1'b1, 4'h4, {7'h00, tap, 7'h00, row});
      bus(1'b1, 4'h8, {16'h0000, m});
      bus(1'b1, 4'h0, {26'h0, c});
      idle();
   endtask : go

   task automatic mdl(input logic [8:0] p, t, input logic e, s);
      chk("pointer", {23'h0, p}, {23'h0, mem_u.ptr_q});
      chk("start", {23'h0, t}, {23'h0, mem_u.tap_q});
      chk("empty", {31'h0, e}, {31'h0, mem_u.empty_q});
      chk("mode", {31'h0, s}, {31'h0, mem_u.smode_q});
   endtask : mdl

   initial begin
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      bus(1'b0, 4'h4, 32'h0);
      chk("addr_reg", 32'h0, rv);
      bus(1'b0, 4'h8, 32'h0);
      chk("mask_reg", 32'hFFFF, rv);
      bus(1'b0, 4'hC, 32'h0);
      chk("status", 32'h0, rv);
      bus(1'b1, 4'h2, 32'hFFFF_FFFF);
      bus(1'b0, 4'h2, 32'h0);
      chk("unmapped", 32'h0, rv);
      go(6'h01, 9'h011, 9'h1A5, 16'h0000);
      mdl(9'h1A5, 9'h1A5, 1'b1, 1'b1);
      chk("row", 32'h011, {23'h0, mem_u.row_q});
      chk("by_oe", 32'h0, {31'h0, mem_u.by_oe_q});
      bus(1'b0, 4'hC, 32'h0);
      chk("status", 32'h6, rv);
      go(6'h03, 9'h022, 9'h1FF, 16'h0000);
      mdl(9'h1A5, 9'h0FF, 1'b0, 1'b1);
      chk("half", 32'h0, {31'h0, mem_u.xhalf_q});
      go(6'h0D, 9'h033, 9'h003, 16'h5A5A);
      mdl(9'h003, 9'h003, 1'b1, 1'b0);
      chk("mask", 32'h5A5A, {16'h0, mem_u.used_q});
      go(6'h07, 9'h044, 9'h080, 16'h1234);
      mdl(9'h003, 9'h080, 1'b0, 1'b0);
      chk("half", 32'h1, {31'h0, mem_u.xhalf_q});
      bus(1'b0, 4'h0, 32'h0);
      chk("ctrl", 32'h06, rv);
      bus(1'b1, 4'h0, 32'h01);
      bus(1'b1, 4'h0, 32'h07);
      idle();
      bus(1'b0, 4'h0, 32'h0);
      chk("ctrl", 32'h00, rv);
      mdl(9'h080, 9'h080, 1'b1, 1'b1);
      go(6'h11, 9'h055, 9'h1F0, 16'h0000);
      chk("by_oe", 32'h1, {31'h0, mem_u.by_oe_q});
      do bus(1'b0, 4'hC, 32'h0); while (rv[1] !== 1'b0);
      chk("status", 32'hC, rv);
      go(6'h13, 9'h066, 9'h040, 16'h0000);
      do bus(1'b0, 4'hC, 32'h0); while (rv[1] !== 1'b1);
      chk("jump", 32'h140, {23'h0, mem_u.jto_q});
      chk("jumps", 32'h1, mem_u.jcnt_q);
      chk("empty", 32'h1, {31'h0, mem_u.empty_q});
      bus(1'b1, 4'h0, 32'h0);
      // Skip-column bit must not stop a write from latching its start column
      go(6'h25, 9'h077, 9'h0AA, 16'h0000);
      mdl(9'h0AA, 9'h0AA, 1'b1, 1'b0);
      // A read may skip it: the start register keeps the last latched column
      go(6'h21, 9'h088, 9'h155, 16'h0000);
      mdl(9'h0AA, 9'h0AA, 1'b1, 1'b1);
      chk("row", 32'h088, {23'h0, mem_u.row_q});
      wrap_up();
   end

   // Whole run is some hundreds of cycles; the 10000-cycle limit leaves ample margin
   initial begin
      #200000;
      n_errors++;
      wrap_up();
   end
endmodule : test_vxc_top

// *** testbench/vxc_mem_model.sv ***
// Behavioural model of the memory's transfer decode, start register and serial pointer
`timescale 1ns/1ps
module vxc_mem_model #(
   parameter logic [7:0] STOP_COL = 8'hFF
) (
   input  wire logic        ras_n,
   input  wire logic        cas_n,
   input  wire logic        transfer_output_enable_n,
   input  wire logic        upper_byte_write_strobe_n,
   input  wire logic        lower_byte_write_strobe_n,
   input  wire logic        function_select,
   input  wire logic [8:0]  addr,
   input  wire logic [15:0] mask_data_pins,
   input  wire logic        serial_clock,
   output logic             half_indicator
);
   logic [8:0]  ptr_q   = 9'h000;
   logic [8:0]  tap_q   = 9'h000;
   logic [8:0]  row_q   = 9'h000;
   logic [8:0]  jto_q   = 9'h000;
   logic [15:0] used_q  = 16'h0000;
   logic        empty_q = 1'b1;
   logic        smode_q = 1'b0;
   logic        xfer_q  = 1'b0;
   logic        wr_q    = 1'b0;
   logic        split_q = 1'b0;
   logic        xhalf_q = 1'b0;
   logic        by_oe_q = 1'b0;
   int          jcnt_q  = 0;

   assign half_indicator = ptr_q[8];

   task load_single;
      ptr_q = tap_q;
      empty_q = 1'b1;
   endtask : load_single

   // Mask is taken from the pins on every write: the model runs the new-mask method only
   always @(negedge ras_n) begin
      xfer_q = cas_n && !transfer_output_enable_n;
      if (xfer_q) begin
         wr_q = !upper_byte_write_strobe_n && !lower_byte_write_strobe_n;
         split_q = function_select;
         row_q = addr;
         by_oe_q = 1'b0;
         if (wr_q) used_q = mask_data_pins;
      end
   end

   always @(negedge cas_n)
      if (!ras_n && xfer_q) begin
         tap_q = split_q ? {1'b0, addr[7:0]} : addr;
         empty_q = 1'b0;
      end

   always @(posedge transfer_output_enable_n)
      if (!ras_n && xfer_q && !wr_q && !split_q) begin
         load_single();
         by_oe_q = 1'b1;
      end

   always @(posedge ras_n)
      if (xfer_q) begin
         xfer_q = 1'b0;
         if (split_q) xhalf_q = !ptr_q[8];
         else begin
            if (!by_oe_q) load_single();
            smode_q = !wr_q;
         end
      end

   always @(posedge serial_clock)
      if (!empty_q && ptr_q[7:0] == STOP_COL && ptr_q[8] != xhalf_q) begin
         jto_q = {xhalf_q, tap_q[7:0]};
         ptr_q = jto_q;
         empty_q = 1'b1;
         jcnt_q++;
      end else ptr_q = ptr_q + 9'h001;
endmodule : vxc_mem_model

// *** testbench/vxc_top_chk.sv ***
// Pin and bus protocol checker bound to the transfer controller
`timescale 1ns/1ps
module vxc_top_chk (
   input wire logic        clk,
   input wire logic        arst_n,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic        avs_waitrequest,
   input wire logic        ras_n,
   input wire logic        cas_n,
   input wire logic        transfer_output_enable_n,
   input wire logic        upper_byte_write_strobe_n,
   input wire logic        function_select,
   input wire logic [8:0]  addr,
   input wire logic [15:0] mask_data_pins_o,
   input wire logic        mask_data_pins_oe_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);

   wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest)
      else $error("bus answer late");
   xfer_select_a: assert property ($fell(ras_n) |-> cas_n && !transfer_output_enable_n)
      else $error("bad transfer select");
   kind_hold_a: assert property (!ras_n && !$past(ras_n) |->
      $stable(function_select) && $stable(upper_byte_write_strobe_n))
      else $error("kind moved under row strobe");
   row_hold_a: assert property ($fell(ras_n) |-> $stable(addr))
      else $error("row not settled");
   wr_cas_a: assert property ($fell(ras_n) && !upper_byte_write_strobe_n |-> ##[1:4] $fell(cas_n))
      else $error("write without column strobe");
   split_top_a: assert property ($fell(cas_n) && function_select |-> !addr[8])
      else $error("split start top bit set");
   mask_drive_a: assert property (!mask_data_pins_oe_n |-> !upper_byte_write_strobe_n &&
      (ras_n || $stable(mask_data_pins_o)))
      else $error("mask pins misdriven");
   oe_release_a: assert property ($rose(ras_n) |-> ##[1:4] transfer_output_enable_n)
      else $error("output enable not released");
endmodule : vxc_top_chk

bind vxc_top vxc_top_chk chk_u (
   .clk(clk),
   .arst_n(arst_n),
   .avs_read(avs_read),
   .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest),
   .ras_n(ras_n),
   .cas_n(cas_n),
   .transfer_output_enable_n(transfer_output_enable_n),
   .upper_byte_write_strobe_n(upper_byte_write_strobe_n),
   .function_select(function_select),
   .addr(addr),
   .mask_data_pins_o(mask_data_pins_o),
   .mask_data_pins_oe_n(mask_data_pins_oe_n)
);
